// ==== src/trig_pkg.sv ====
package trig_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_LEN1 = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_LEN2 = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_EVTARGET = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_QUALEN = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_ALMDUAL = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_TRIGCNT = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_EVCOUNT = 6'h20;
  localparam int REARM_BIT = 31;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Interval counters
  // ----------------------------------------------------------------
  localparam int LEN_W = 16;
  localparam logic [LEN_W-1:0] LEN_MIN = 16'h0002;
  localparam logic [LEN_W-1:0] LEN_RESET = 16'h0002;
  localparam logic [LEN_W-1:0] EVT_RESET = 16'h0001;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_LESS = 3'h1,
    MODE_MORE = 3'h2,
    MODE_BETWEEN = 3'h3,
    outside_window_mode = 3'h4
  } itv_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_T1 = 2'h1,
    ST_T2 = 2'h3
  } itv_state_e;

  // Control word; the top bit is the write-only rearm strobe.
  typedef struct packed {
    logic rearm;
    logic [13:0] rsvd;
    logic sync_accept;
    logic sync_drive;
    logic sync_mode;
    logic [2:0] line_accept;
    logic [2:0] line_drive;
    logic ext_out_low;
    logic ext_out_en;
    logic ext_in_falling;
    logic ext_in_en;
    logic evcnt_en;
    logic [2:0] itv_mode;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '0;

endpackage : trig_pkg

// ==== src/trig_combine.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Less: event inside interval gives trigger.
// - Less: first event after completion restarts interval.
// - More: early event suppresses trigger, restarts interval.
// - More: trigger at interval end if no event.
// - Between: first counter delays window, second sizes it.
// - Between: event during first counter restarts it.
// - Between/Outside: first counter expiry starts the second counter.
// - Between: silent second counter expiry resets logic.
// - Between: event during second counter gives trigger.
// - Outside: event during first counter gives trigger.
// - Outside: event in second counter restarts first.
// - Outside: second counter expiry gives trigger.
// - Event counter triggers when count equals target.
// - Channel triggers are ORed into combined trigger.
// - Unarmed enabled qualifier blocks recorder trigger.
// - External input: common edge, per-card enable.
// - External output: common polarity, per-card enable.
// - Three shared lines: selectable drive and accept.
// - Sync line drivable, receivable, else ordinary line.
// - Single-level alarm follows level exceed condition.
// - Dual-level alarm follows either exceed condition.
// - All alarm conditions ORed onto one output.
// - Interval lengths count samples, 2 to 65535.
module trig_combine #(
  parameter int N_CH = 8,
  parameter int N_QUAL = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [trig_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [trig_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [N_CH-1:0] ch_trig,
  input wire logic [N_QUAL-1:0] qual_armed,
  input wire logic [N_CH-1:0] ch_over_primary,
  input wire logic [N_CH-1:0] ch_over_secondary,
  input wire logic ext_trig_in,
  input wire logic [2:0] line_in,
  input wire logic sync_in,
  input wire logic alarm_in,
  output logic ext_trig_out,
  output logic [2:0] line_out,
  output logic sync_out,
  output logic rec_trig,
  output logic alarm_out
);
  import trig_pkg::*;

  if (N_CH < 1 || N_CH > 32 || N_QUAL < 1 || N_QUAL > 32) begin : g_bad_param
    $error("trig_combine: N_CH and N_QUAL must lie in 1..32");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // Lengths below the minimum act as the minimum.
  function automatic logic [LEN_W-1:0] clamp(input logic [LEN_W-1:0] v, input logic [LEN_W-1:0] lo);
    return (v < lo) ? lo : v;
  endfunction : clamp

  // ----------------------------------------------------------------
  // Registers and AXI4-Lite slave
  // ----------------------------------------------------------------
  ctrl_s ctrl;
  logic [LEN_W-1:0] len1;
  logic [LEN_W-1:0] len2;
  logic [LEN_W-1:0] ev_target;
  logic [N_QUAL-1:0] qual_en;
  logic [N_CH-1:0] alarm_dual;
  logic [31:0] trig_count;
  logic [LEN_W-1:0] ev_count;
  logic aw_got;
  logic w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic rearm;
  itv_state_e state;
  logic [LEN_W-1:0] cnt;
  logic qual_ok_q;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_got & w_got & ~s_axi_bvalid;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire next_aw_got = aw_take | (aw_got & ~do_write);
  wire next_w_got = w_take | (w_got & ~do_write);
  wire next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [ADDR_W-1:0] wa = {aw_addr[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire wr_hit = (wa <= OFS_ALMDUAL);
  wire rd_hit = (ra <= OFS_EVCOUNT);
  wire [31:0] wr_val = merge(32'h0, w_data, w_strb);
  wire [31:0] status_word = {28'h0, alarm_out, qual_ok_q, state};
  wire [31:0] rd_val =
    (ra == OFS_CTRL) ? {1'b0, 31'(ctrl)} :
    (ra == OFS_LEN1) ? {16'h0, len1} :
    (ra == OFS_LEN2) ? {16'h0, len2} :
    (ra == OFS_EVTARGET) ? {16'h0, ev_target} :
    (ra == OFS_QUALEN) ? 32'(qual_en) :
    (ra == OFS_ALMDUAL) ? 32'(alarm_dual) :
    (ra == OFS_STATUS) ? status_word :
    (ra == OFS_TRIGCNT) ? trig_count :
    (ra == OFS_EVCOUNT) ? {16'h0, ev_count} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= ~next_aw_got & ~next_bvalid;
      s_axi_wready <= ~next_w_got & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_hit ? rd_val : 32'h0;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      len1 <= LEN_RESET;
      len2 <= LEN_RESET;
      ev_target <= EVT_RESET;
      qual_en <= '0;
      alarm_dual <= '0;
      rearm <= 1'b0;
    end else begin
      rearm <= do_write && wa == OFS_CTRL && w_strb[3] && w_data[REARM_BIT];
      if (do_write) begin
        unique case (wa)
          OFS_CTRL: ctrl <= ctrl_s'(merge(32'(ctrl), w_data, w_strb) & 32'h0001ffff);
          OFS_LEN1: len1 <= wr_val[LEN_W-1:0];
          OFS_LEN2: len2 <= wr_val[LEN_W-1:0];
          OFS_EVTARGET: ev_target <= wr_val[LEN_W-1:0];
          OFS_QUALEN: qual_en <= wr_val[N_QUAL-1:0];
          OFS_ALMDUAL: alarm_dual <= wr_val[N_CH-1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_m;
  logic [5:0] pin_s;
  logic ext_prev;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_m <= 6'h0;
      pin_s <= 6'h0;
      ext_prev <= 1'b0;
    end else begin
      pin_m <= {alarm_in, sync_in, line_in, ext_trig_in};
      pin_s <= pin_m;
      ext_prev <= pin_s[0];
    end
  end
  wire ext_edge = ctrl.ext_in_falling ? (ext_prev & ~pin_s[0]) : (~ext_prev & pin_s[0]);

  // ----------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------
  wire ev = |ch_trig;
  wire [LEN_W-1:0] load1 = LEN_W'(clamp(len1, LEN_MIN) - 16'h0001);
  wire [LEN_W-1:0] load2 = LEN_W'(clamp(len2, LEN_MIN) - 16'h0001);
  wire expired = (cnt == 16'h0000);
  wire [2:0] mode = ctrl.itv_mode;
  itv_state_e next_state;
  logic [LEN_W-1:0] next_cnt;
  logic itv_hit;
  logic itv_trig;

  always_comb begin
    next_state = state;
    next_cnt = (cnt == 16'h0000) ? cnt : LEN_W'(cnt - 16'h0001);
    itv_hit = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (ev) begin
          next_state = ST_T1;
          next_cnt = load1;
        end
      end
      ST_T1: begin
        if (ev && (mode == MODE_LESS || mode == outside_window_mode)) begin
          itv_hit = 1'b1;
          next_state = ST_IDLE;
        end else if (ev) begin
          next_cnt = load1;
        end else if (expired && mode == MODE_MORE) begin
          itv_hit = 1'b1;
          next_state = ST_IDLE;
        end else if (expired && (mode == MODE_BETWEEN || mode == outside_window_mode)) begin
          next_state = ST_T2;
          next_cnt = load2;
        end else if (expired) begin
          next_state = ST_IDLE;
        end
      end
      ST_T2: begin
        if (ev && mode == outside_window_mode) begin
          next_state = ST_T1;
          next_cnt = load1;
        end else if (ev) begin
          itv_hit = 1'b1;
          next_state = ST_IDLE;
        end else if (expired) begin
          itv_hit = (mode == outside_window_mode);
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (mode == MODE_OFF || mode > outside_window_mode) begin
      next_state = ST_IDLE;
      itv_hit = ev;
    end
  end

  // ----------------------------------------------------------------
  // Event counter and recorder combine
  // ----------------------------------------------------------------
  wire [LEN_W-1:0] target = clamp(ev_target, 16'h0001);
  wire [LEN_W-1:0] ev_inc = LEN_W'(ev_count + 16'h0001);
  wire ev_done = itv_trig & (ev_inc == target);
  wire chan_trig = ctrl.evcnt_en ? ev_done : itv_trig;
  wire line_hit = |(ctrl.line_accept & pin_s[3:1]);
  wire sync_hit = ctrl.sync_accept & pin_s[4];
  wire any_src = chan_trig | (ctrl.ext_in_en & ext_edge) | line_hit | sync_hit;
  wire qual_ok = &(~qual_en | qual_armed);
  wire next_rec = any_src & qual_ok & ~rearm;
  wire [N_CH-1:0] ch_alarm = ch_over_primary | (alarm_dual & ch_over_secondary);
  wire next_alarm = (|ch_alarm) | pin_s[5];

  always_ff @(posedge aclk) begin
    if (!aresetn || rearm) begin
      state <= ST_IDLE;
      cnt <= 16'h0000;
      itv_trig <= 1'b0;
      ev_count <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      itv_trig <= itv_hit;
      if (ctrl.evcnt_en && itv_trig) begin
        ev_count <= ev_done ? 16'h0000 : ev_inc;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rec_trig <= 1'b0;
      ext_trig_out <= 1'b0;
      line_out <= 3'h0;
      sync_out <= 1'b0;
      alarm_out <= 1'b0;
      trig_count <= 32'h0;
      qual_ok_q <= 1'b0;
    end else begin
      rec_trig <= next_rec;
      ext_trig_out <= ctrl.ext_out_low ^ (ctrl.ext_out_en & next_rec);
      line_out <= ctrl.line_drive & {3{next_rec}};
      sync_out <= ctrl.sync_mode & ctrl.sync_drive & next_rec;
      alarm_out <= next_alarm;
      qual_ok_q <= qual_ok;
      if (next_rec) begin
        trig_count <= trig_count + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_less_hit: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_LESS && state == ST_T1 && ev && !rearm) |=> itv_trig && state == ST_IDLE)
    else $error("less mode missed a trigger");
  a_less_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_LESS && state == ST_IDLE && ev && !rearm) |=> state == ST_T1 && cnt == $past(load1))
    else $error("less mode did not restart");
  a_more_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_MORE && state == ST_T1 && ev && !rearm) |=> !itv_trig && cnt == $past(load1))
    else $error("more mode did not reload");
  a_more_expire: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_MORE && state == ST_T1 && expired && !ev && !rearm) |=> itv_trig)
    else $error("more mode missed expiry trigger");
  a_window_open: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_BETWEEN && state == ST_T1 && expired && !ev && !rearm) |=> state == ST_T2 && cnt == $past(load2))
    else $error("second counter not started");
  a_between_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_BETWEEN && state == ST_T2 && expired && !ev && !rearm) |=> state == ST_IDLE && !itv_trig)
    else $error("between window did not reset");
  a_outside_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == outside_window_mode && state == ST_T2 && ev && !rearm) |=> state == ST_T1 && !itv_trig)
    else $error("outside window event not handled");
  a_outside_late: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == outside_window_mode && state == ST_T2 && expired && !ev && !rearm) |=> itv_trig)
    else $error("outside window expiry missed");
  a_qual_block: assert property (@(posedge aclk) disable iff (!aresetn)
    !qual_ok |=> !rec_trig && line_out == 3'h0)
    else $error("trigger passed an unarmed qualifier");
  a_alarm_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    (|ch_over_primary) |=> alarm_out)
    else $error("alarm not raised");

endmodule : trig_combine

// ==== tb/detector_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Channel level detectors feeding the trigger logic
// ----------------------------------------------------------------
module detector_model #(
  parameter int N_CH = 4
) (
  input wire logic aclk,
  input wire logic [N_CH-1:0] prim_lvl,
  input wire logic [N_CH-1:0] sec_lvl,
  output logic [N_CH-1:0] ch_trig,
  output logic [N_CH-1:0] ch_over_primary,
  output logic [N_CH-1:0] ch_over_secondary
);
  logic [N_CH-1:0] prim_q;

  // A level crossing gives a single event pulse, while the exceed flags follow the level.
  always @(posedge aclk) begin
    prim_q <= prim_lvl;
    ch_trig <= prim_lvl & ~prim_q;
    ch_over_primary <= prim_lvl;
    ch_over_secondary <= sec_lvl;
  end
endmodule : detector_model

// ==== tb/trigger_interval_combine_logic_tb.sv ====
`timescale 1ns/1ps
module trigger_interval_combine_logic_tb;
  import trig_pkg::*;
  localparam int N_CH = 4;
  localparam int N_QUAL = 2;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [N_CH-1:0] ch_trig, prim_lvl, sec_lvl, ovp, ovs;
  logic [N_QUAL-1:0] qual_armed;
  logic ext_trig_in, sync_in, alarm_in, ext_trig_out, sync_out, rec_trig, alarm_out, ext_acc, sync_acc;
  logic [2:0] line_in, line_out, line_acc;
  int fail_count, check_count, trig_seen, base, i;
  ctrl_s cw;

  trig_combine #(.N_CH(N_CH), .N_QUAL(N_QUAL)) trig_combine_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ch_trig(ch_trig), .qual_armed(qual_armed), .ch_over_primary(ovp),
    .ch_over_secondary(ovs), .ext_trig_in(ext_trig_in), .line_in(line_in), .sync_in(sync_in),
    .alarm_in(alarm_in), .ext_trig_out(ext_trig_out), .line_out(line_out), .sync_out(sync_out),
    .rec_trig(rec_trig), .alarm_out(alarm_out));

  detector_model #(.N_CH(N_CH)) detector_model_i (.aclk(aclk), .prim_lvl(prim_lvl), .sec_lvl(sec_lvl),
    .ch_trig(ch_trig), .ch_over_primary(ovp), .ch_over_secondary(ovs));

  // ----------------------------------------------------------------
  // Clock, trigger monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Sampled on the falling edge so the flops have settled.
  always @(negedge aclk) begin
    if (rec_trig === 1'b1) begin
      trig_seen++;
      ext_acc = ext_trig_out;
      line_acc = line_acc | line_out;
      sync_acc = sync_acc | sync_out;
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd_reg

  task automatic gap(input int n);
    repeat (n) @(posedge aclk);
  endtask : gap

  task automatic ev(input int ch);
    prim_lvl[ch] <= 1'b1;
    @(posedge aclk);
    prim_lvl[ch] <= 1'b0;
  endtask : ev

  task automatic setc(input logic [2:0] m);
    cw.itv_mode = m;
    wr(OFS_CTRL, cw);
  endtask : setc

  task automatic expn(input string nm, input int n);
    chk(nm, 32'(trig_seen - base), 32'(n));
    base = trig_seen;
  endtask : expn

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_trig_in, sync_in, alarm_in} = '0;
    {awaddr, araddr, wdata, wstrb, prim_lvl, sec_lvl, qual_armed, line_in} = '0;
    {fail_count, check_count, trig_seen, base} = '0;
    {ext_acc, sync_acc, line_acc} = '0;
    cw = CTRL_RESET;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_reg(OFS_CTRL);
    chk("ctrl reset", rd, 32'h0);
    rd_reg(OFS_LEN1);
    chk("len1 reset", rd, {16'h0, LEN_RESET});
    rd_reg(OFS_EVTARGET);
    chk("target reset", rd, {16'h0, EVT_RESET});
    rd_reg(6'h24);
    chk("unmapped read", {30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFS_STATUS, 32'h3);
    chk("read-only write", {30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFS_QUALEN, 32'h0);
    setc(MODE_OFF);
    ev(0);
    gap(4);
    ev(N_CH - 1);
    gap(6);
    expn("or combine", 2);
    wr(OFS_LEN1, 32'd5);
    setc(MODE_LESS);
    ev(1);
    gap(2);
    ev(1);
    gap(8);
    expn("less inside", 1);
    ev(0);
    gap(11);
    ev(0);
    gap(2);
    ev(2);
    gap(8);
    expn("less restart", 1);
    wr(OFS_LEN1, 32'd40);
    ev(1);
    cw.rearm = 1'b1;
    wr(OFS_CTRL, cw);
    cw.rearm = 1'b0;
    ev(1);
    gap(8);
    expn("rearm clears", 0);
    ev(1);
    gap(8);
    expn("after rearm", 1);
    rd_reg(OFS_CTRL);
    chk("rearm reads 0", {31'h0, rd[REARM_BIT]}, 32'h0);
    gap(45);
    wr(OFS_LEN1, 32'd4);
    setc(MODE_MORE);
    ev(0);
    gap(1);
    ev(0);
    gap(1);
    ev(0);
    gap(2);
    expn("more suppress", 0);
    gap(10);
    expn("more at end", 1);
    wr(OFS_LEN2, 32'd4);
    setc(MODE_BETWEEN);
    ev(0);
    gap(5);
    ev(0);
    gap(8);
    expn("between window", 1);
    ev(0);
    gap(20);
    expn("between expire", 0);
    ev(0);
    gap(1);
    ev(0);
    gap(2);
    ev(0);
    gap(20);
    expn("between restart", 0);
    setc(outside_window_mode);
    ev(0);
    gap(1);
    ev(0);
    gap(8);
    expn("outside early", 1);
    ev(0);
    gap(20);
    expn("outside late", 1);
    ev(0);
    gap(5);
    ev(0);
    gap(2);
    expn("outside in second", 0);
    rd_reg(OFS_STATUS);
    chk("state back in first", rd, 32'h5);
    gap(20);
    expn("outside resumed", 1);
    wr(OFS_EVTARGET, 32'd3);
    cw.evcnt_en = 1'b1;
    setc(MODE_OFF);
    for (i = 0; i < 6; i++) begin
      ev(i % N_CH);
      gap(2);
    end
    gap(6);
    expn("event count", 2);
    rd_reg(OFS_EVCOUNT);
    chk("event count reg", rd, 32'h0);
    cw.evcnt_en = 1'b0;
    wr(OFS_QUALEN, 32'h1);
    setc(MODE_OFF);
    ev(1);
    gap(6);
    expn("qual blocked", 0);
    qual_armed <= 2'b01;
    ev(1);
    gap(6);
    expn("qual armed", 1);
    wr(OFS_QUALEN, 32'h0);
    for (i = 0; i < 3; i++) begin
      cw.ext_in_en = (i < 2);
      cw.ext_in_falling = (i == 1);
      setc(MODE_OFF);
      ext_trig_in <= 1'b1;
      gap(8);
      ext_trig_in <= 1'b0;
      gap(8);
      expn("ext in edge", (i < 2) ? 1 : 0);
    end
    cw.ext_out_en = 1'b1;
    cw.ext_out_low = 1'b1;
    cw.line_drive = 3'b101;
    cw.sync_mode = 1'b1;
    cw.sync_drive = 1'b1;
    setc(MODE_OFF);
    gap(2);
    chk("ext out idle", {31'h0, ext_trig_out}, 32'h1);
    ext_acc = 1'b1;
    ev(2);
    gap(6);
    chk("ext out active", {31'h0, ext_acc}, 32'h0);
    chk("lines driven", {29'h0, line_acc}, 32'h5);
    chk("sync driven", {31'h0, sync_acc}, 32'h1);
    cw.sync_mode = 1'b0;
    setc(MODE_OFF);
    sync_acc = 1'b0;
    ev(2);
    gap(6);
    chk("sync not driven", {31'h0, sync_acc}, 32'h0);
    expn("output triggers", 2);
    cw = CTRL_RESET;
    cw.line_accept = 3'b010;
    cw.sync_accept = 1'b1;
    setc(MODE_OFF);
    for (i = 0; i < 3; i++) begin
      line_in <= (i == 0) ? 3'b001 : (i == 1) ? 3'b010 : 3'b000;
      sync_in <= (i == 2);
      @(posedge aclk);
      line_in <= 3'b000;
      sync_in <= 1'b0;
      gap(8);
      expn("line or sync accept", (i == 0) ? 0 : 1);
    end
    prim_lvl[2] <= 1'b1;
    gap(6);
    chk("alarm primary", {31'h0, alarm_out}, 32'h1);
    prim_lvl[2] <= 1'b0;
    sec_lvl[1] <= 1'b1;
    gap(6);
    chk("alarm single", {31'h0, alarm_out}, 32'h0);
    wr(OFS_ALMDUAL, 32'h2);
    gap(4);
    chk("alarm dual", {31'h0, alarm_out}, 32'h1);
    sec_lvl[1] <= 1'b0;
    wr(OFS_ALMDUAL, 32'h0);
    alarm_in <= 1'b1;
    gap(6);
    chk("alarm from others", {31'h0, alarm_out}, 32'h1);
    alarm_in <= 1'b0;
    gap(6);
    chk("alarm clear", {31'h0, alarm_out}, 32'h0);
    stop_test();
  end
endmodule : trigger_interval_combine_logic_tb
